//--- lowpower_pkg.sv
package lowpower_pkg;
   // ----------------------------------------------------------------
   // Register map (word indices, one aligned word each; byte address is index times 4)
   // ----------------------------------------------------------------
   localparam logic [15:0] BREAK_STATUS_IDX       = 16'hFE00;
   localparam logic [15:0] RESET_CAUSE_STATUS_IDX = 16'hFE01;
   localparam logic [15:0] BREAK_FLAG_CONTROL_IDX = 16'hFE03;
   localparam logic [15:0] LOWPOWER_CONTROL_IDX   = 16'hFE04;
   localparam int          ADDR_W                 = 18;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BREAK_EXIT_BIT       = 1;
   localparam int BREAK_CLEAR_EN_BIT   = 7;
   localparam int RC_POWER_ON_BIT      = 7;
   localparam int RC_PIN_BIT           = 6;
   localparam int RC_WATCHDOG_BIT      = 5;
   localparam int RC_ILL_OPCODE_BIT    = 4;
   localparam int RC_ILL_ADDRESS_BIT   = 3;
   localparam int RC_LOW_VOLTAGE_BIT   = 1;
   localparam int CTL_SHORT_REC_BIT    = 0;
   localparam int CTL_WDOG_DIS_BIT     = 1;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RESET_CAUSE_POR_VAL = 8'h80;
   localparam logic       BREAK_CLEAR_EN_RST  = 1'b0;
   localparam logic [1:0] CONTROL_RST         = 2'h0;
   // ----------------------------------------------------------------
   // Timing: recovery in crystal clock cycles
   // ----------------------------------------------------------------
   localparam int STOP_REC_LONG_CYC  = 4096;
   localparam int STOP_REC_SHORT_CYC = 32;
   localparam int REC_CNT_W          = 13;

   typedef enum logic [2:0] {
      ST_RUN     = 3'b000,
      ST_WAIT    = 3'b001,
      ST_STOP    = 3'b010,
      ST_RECOVER = 3'b011,
      ST_RESUME  = 3'b100
   } lp_state_t;
endpackage : lowpower_pkg

//--- recovery_counter.sv
`timescale 1ns/1ps
`default_nettype none
// Counter that stays cleared while held, then counts up
module recovery_counter #(
   parameter int W = 13
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic         hold_in,
   input  wire logic [W-1:0] limit_in,
   output logic              done_out
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge clk_in) begin
      if (rst_in || hold_in) begin
         cnt_q <= '0;
      end else if (cnt_q != limit_in) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || hold_in) begin
         done_out <= 1'b0;
      end else begin
         done_out <= (cnt_q == limit_in - 1'b1) || (cnt_q == limit_in);
      end
   end
endmodule : recovery_counter
`default_nettype wire

//--- lowpower_mode_and_sys_status.sv
`timescale 1ns/1ps
`default_nettype none
module lowpower_mode_and_sys_status #(
   parameter int STOP_REC_LONG = lowpower_pkg::STOP_REC_LONG_CYC
) (
   input  wire logic                         clk_in,
   input  wire logic                         rst_in,
   // Avalon-MM slave
   input  wire logic [lowpower_pkg::ADDR_W-1:0] avs_address_in,
   input  wire logic                         avs_read_in,
   input  wire logic                         avs_write_in,
   input  wire logic [31:0]                  avs_writedata_in,
   input  wire logic [3:0]                   avs_byteenable_in,
   output logic      [31:0]                  avs_readdata_out,
   output logic                              avs_waitrequest_out,
   // CPU side
   input  wire logic                         stop_instr_in,
   input  wire logic                         wait_instr_in,
   input  wire logic                         cpu_irq_in,
   input  wire logic                         break_irq_in,
   input  wire logic                         reset_pin_in,
   input  wire logic                         break_mode_in,
   output logic                              clear_imask_out,
   output logic                              cpu_clk_en_out,
   output logic                              periph_clk_en_out,
   output logic                              base_clock_output_en_out,
   output logic                              crystal_clock_en_out,
   output logic                              stacking_start_out,
   output logic                              lowpower_exit_out,
   output logic                              watchdog_run_out,
   // Reset causes, sampled on the first edge after reset release
   input  wire logic                         por_cause_in,
   input  wire logic                         pin_cause_in,
   input  wire logic                         wdog_cause_in,
   input  wire logic                         ill_opcode_cause_in,
   input  wire logic                         ill_fetch_cause_in,
   input  wire logic                         low_voltage_cause_in,
   // Status flag protection for peripheral modules
   output logic                              flag_clear_allow_out,
   output logic                              second_step_allow_out
);
   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   function automatic logic hit(
      input logic [lowpower_pkg::ADDR_W-1:0] a,
      input logic [15:0]                     idx
   );
      hit = (a == {idx, 2'b00});
   endfunction : hit

   logic                 acc_q;
   logic                 rd_hit_cause;
   logic                 wr_break_status;
   logic                 wr_flag_ctl;
   logic                 wr_ctl;
   logic                 req;
   logic                 lp_exit;
   logic                 break_clear_enable_q;
   logic [1:0]           ctl_q;
   logic                 break_exit_flag_q;
   logic [7:0]           reset_cause_q;
   logic                 rst_seen_q;
   logic                 rec_done;
   logic                 rec_hold;
   logic [lowpower_pkg::REC_CNT_W-1:0] rec_limit;
   lowpower_pkg::lp_state_t state_q;
   lowpower_pkg::lp_state_t state_d;

   // One wait state: request seen, answered on next edge
   assign req             = (avs_read_in || avs_write_in) && !acc_q;
   assign wr_break_status = avs_write_in && acc_q && avs_byteenable_in[0]
                            && hit(avs_address_in,
                                   lowpower_pkg::BREAK_STATUS_IDX);
   assign wr_flag_ctl     = avs_write_in && acc_q && avs_byteenable_in[0]
                            && hit(avs_address_in,
                                   lowpower_pkg::BREAK_FLAG_CONTROL_IDX);
   assign wr_ctl          = avs_write_in && acc_q && avs_byteenable_in[0]
                            && hit(avs_address_in,
                                   lowpower_pkg::LOWPOWER_CONTROL_IDX);
   assign rd_hit_cause    = avs_read_in && acc_q
                            && hit(avs_address_in,
                                   lowpower_pkg::RESET_CAUSE_STATUS_IDX);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         acc_q <= 1'b0;
      end else begin
         acc_q <= req;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         avs_waitrequest_out <= 1'b1;
      end else begin
         avs_waitrequest_out <= !req;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         avs_readdata_out <= 32'h0000_0000;
      end else if (req && avs_read_in) begin
         avs_readdata_out <= 32'h0000_0000;
         if (hit(avs_address_in, lowpower_pkg::BREAK_STATUS_IDX)) begin
            avs_readdata_out[lowpower_pkg::BREAK_EXIT_BIT] <=
               break_exit_flag_q;
         end
         if (hit(avs_address_in, lowpower_pkg::RESET_CAUSE_STATUS_IDX)) begin
            avs_readdata_out[7:0] <= reset_cause_q;
         end
         if (hit(avs_address_in, lowpower_pkg::BREAK_FLAG_CONTROL_IDX)) begin
            avs_readdata_out[lowpower_pkg::BREAK_CLEAR_EN_BIT] <=
               break_clear_enable_q;
         end
         if (hit(avs_address_in, lowpower_pkg::LOWPOWER_CONTROL_IDX)) begin
            avs_readdata_out[1:0] <= ctl_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         break_clear_enable_q <= lowpower_pkg::BREAK_CLEAR_EN_RST;
      end else if (wr_flag_ctl) begin
         break_clear_enable_q <=
            avs_writedata_in[lowpower_pkg::BREAK_CLEAR_EN_BIT];
      end
   end

   // Short recovery meant for canned oscillators only
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ctl_q <= lowpower_pkg::CONTROL_RST;
      end else if (wr_ctl) begin
         ctl_q <= avs_writedata_in[1:0];
      end
   end

   // Set wins over a write of 0 in the same cycle
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         break_exit_flag_q <= 1'b0;
      end else if (break_irq_in && (state_q == lowpower_pkg::ST_WAIT
                   || state_q == lowpower_pkg::ST_STOP)) begin
         break_exit_flag_q <= 1'b1;
      end else if (wr_break_status
                   && !avs_writedata_in[lowpower_pkg::BREAK_EXIT_BIT]) begin
         break_exit_flag_q <= 1'b0;
      end
   end

   // Causes are caught on the first edge after reset release
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rst_seen_q <= 1'b0;
      end else begin
         rst_seen_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         reset_cause_q <= 8'h00;
      end else if (!rst_seen_q) begin
         if (por_cause_in) begin
            reset_cause_q <= lowpower_pkg::RESET_CAUSE_POR_VAL;
         end else begin
            reset_cause_q <= 8'h00;
            reset_cause_q[lowpower_pkg::RC_PIN_BIT] <= pin_cause_in;
            reset_cause_q[lowpower_pkg::RC_WATCHDOG_BIT] <= wdog_cause_in;
            reset_cause_q[lowpower_pkg::RC_ILL_OPCODE_BIT] <=
               ill_opcode_cause_in;
            reset_cause_q[lowpower_pkg::RC_ILL_ADDRESS_BIT] <=
               ill_fetch_cause_in;
            reset_cause_q[lowpower_pkg::RC_LOW_VOLTAGE_BIT] <=
               low_voltage_cause_in;
         end
      end else if (rd_hit_cause) begin
         reset_cause_q <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Low-power sequencing
   // ----------------------------------------------------------------
   assign lp_exit   = reset_pin_in || cpu_irq_in || break_irq_in;
   assign rec_hold  = (state_q != lowpower_pkg::ST_RECOVER);
   assign rec_limit = ctl_q[lowpower_pkg::CTL_SHORT_REC_BIT]
      ? lowpower_pkg::REC_CNT_W'(lowpower_pkg::STOP_REC_SHORT_CYC)
      : lowpower_pkg::REC_CNT_W'(STOP_REC_LONG);

   recovery_counter #(
      .W (lowpower_pkg::REC_CNT_W)
   ) u_rec (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .hold_in  (rec_hold),
      .limit_in (rec_limit),
      .done_out (rec_done)
   );

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         lowpower_pkg::ST_RUN: begin
            if (stop_instr_in) begin
               state_d = lowpower_pkg::ST_STOP;
            end else if (wait_instr_in) begin
               state_d = lowpower_pkg::ST_WAIT;
            end
         end
         lowpower_pkg::ST_WAIT: begin
            if (lp_exit) begin
               state_d = lowpower_pkg::ST_RESUME;
            end
         end
         lowpower_pkg::ST_STOP: begin
            if (lp_exit) begin
               state_d = lowpower_pkg::ST_RECOVER;
            end
         end
         lowpower_pkg::ST_RECOVER: begin
            if (rec_done) begin
               state_d = lowpower_pkg::ST_RESUME;
            end
         end
         lowpower_pkg::ST_RESUME: begin
            state_d = lowpower_pkg::ST_RUN;
         end
         default: begin
            state_d = lowpower_pkg::ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_q <= lowpower_pkg::ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all registered
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         clear_imask_out <= 1'b0;
      end else begin
         clear_imask_out <= (state_q == lowpower_pkg::ST_RUN)
                            && (stop_instr_in || wait_instr_in);
      end
   end

   // CPU clock off in wait, stop and recover, on again in resume and run
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cpu_clk_en_out <= 1'b1;
      end else begin
         cpu_clk_en_out <= (state_d == lowpower_pkg::ST_RUN)
                           || (state_d == lowpower_pkg::ST_RESUME);
      end
   end

   // Stop gates every system clock; recovery restores base and crystal clocks first, the peripheral clock only at resume
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         periph_clk_en_out        <= 1'b1;
         base_clock_output_en_out <= 1'b1;
         crystal_clock_en_out     <= 1'b1;
      end else begin
         periph_clk_en_out        <= (state_d != lowpower_pkg::ST_STOP)
                                     && (state_d != lowpower_pkg::ST_RECOVER);
         base_clock_output_en_out <= (state_d != lowpower_pkg::ST_STOP);
         crystal_clock_en_out     <= (state_d != lowpower_pkg::ST_STOP);
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         stacking_start_out <= 1'b0;
      end else begin
         stacking_start_out <= (state_q == lowpower_pkg::ST_RESUME)
                               && !reset_pin_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         lowpower_exit_out <= 1'b0;
      end else begin
         lowpower_exit_out <= lp_exit;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         watchdog_run_out <= 1'b1;
      end else begin
         watchdog_run_out <= !ctl_q[lowpower_pkg::CTL_WDOG_DIS_BIT]
                             && (state_d != lowpower_pkg::ST_STOP)
                             && (state_d != lowpower_pkg::ST_RECOVER);
      end
   end

   // Peripherals gate their clears with these; a clear done while
   // allowed is final, so nothing here restores a flag
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         flag_clear_allow_out  <= 1'b1;
         second_step_allow_out <= 1'b1;
      end else begin
         flag_clear_allow_out  <= !break_mode_in || break_clear_enable_q;
         second_step_allow_out <= !break_mode_in;
      end
   end
endmodule : lowpower_mode_and_sys_status
`default_nettype wire

//--- lowpower_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module lowpower_checker #(
   parameter int STOP_REC_LONG = 4096
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic avs_waitrequest_out,
   input wire logic stop_instr_in,
   input wire logic wait_instr_in,
   input wire logic cpu_irq_in,
   input wire logic break_irq_in,
   input wire logic reset_pin_in,
   input wire logic break_mode_in,
   input wire logic clear_imask_out,
   input wire logic cpu_clk_en_out,
   input wire logic periph_clk_en_out,
   input wire logic base_clock_output_en_out,
   input wire logic crystal_clock_en_out,
   input wire logic stacking_start_out,
   input wire logic lowpower_exit_out,
   input wire logic watchdog_run_out,
   input wire logic flag_clear_allow_out,
   input wire logic second_step_allow_out
);
   localparam int SHORT = 32;
   localparam int LONG  = STOP_REC_LONG;
   logic [15:0] rec_q;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // ----------------------------------------------------------------
   // Recovery length: tolerance covers the entry and exit handshakes
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (rst_in || periph_clk_en_out || !crystal_clock_en_out) begin
         rec_q <= 16'h0000;
      end else begin
         rec_q <= rec_q + 16'h0001;
      end
   end
   a_imask_on_entry: assert property ((stop_instr_in || wait_instr_in) &&
      cpu_clk_en_out |=> clear_imask_out) else $error("mask not cleared");
   a_stop_gates_all: assert property (stop_instr_in && cpu_clk_en_out
      |-> ##2 !(cpu_clk_en_out || periph_clk_en_out || crystal_clock_en_out
      || base_clock_output_en_out)) else $error("stop left a clock on");
   a_wait_gates_cpu: assert property (wait_instr_in && cpu_clk_en_out
      |-> ##2 !cpu_clk_en_out && periph_clk_en_out && crystal_clock_en_out)
      else $error("wait clocks wrong");
   a_exit_is_or: assert property (lowpower_exit_out ==
      $past(reset_pin_in || cpu_irq_in || break_irq_in)) else $error("exit");
   a_wait_wake_stack: assert property ((cpu_irq_in || break_irq_in)
      && !reset_pin_in && !cpu_clk_en_out && periph_clk_en_out
      |-> ##[1:5] stacking_start_out) else $error("wait wake without stacking");
   a_stack_clocks_on: assert property (stacking_start_out |->
      cpu_clk_en_out && periph_clk_en_out && crystal_clock_en_out
      && base_clock_output_en_out) else $error("stacking with clocks off");
   a_recovery_time: assert property ($rose(periph_clk_en_out) &&
      $past(crystal_clock_en_out) |-> rec_q inside
      {[SHORT-3:SHORT+3], [LONG-3:LONG+3]}) else $error("recovery length");
   a_watchdog_in_wait: assert property (wait_instr_in && cpu_clk_en_out
      && watchdog_run_out |-> ##2 watchdog_run_out) else $error("watchdog");
   a_clear_allowed: assert property (!$past(break_mode_in) |->
      flag_clear_allow_out) else $error("clear blocked outside break");
   a_second_step: assert property (second_step_allow_out ==
      !$past(break_mode_in)) else $error("second step allow wrong");
   a_bus_answer: assert property ($rose(avs_read_in || avs_write_in)
      |=> !avs_waitrequest_out) else $error("no bus answer");
endmodule : lowpower_checker
bind lowpower_mode_and_sys_status lowpower_checker #(
   .STOP_REC_LONG(STOP_REC_LONG)) lowpower_checker_i (.clk_in, .rst_in,
   .avs_read_in, .avs_write_in, .avs_waitrequest_out, .stop_instr_in,
   .wait_instr_in, .cpu_irq_in, .break_irq_in, .reset_pin_in, .break_mode_in,
   .clear_imask_out, .cpu_clk_en_out, .periph_clk_en_out,
   .base_clock_output_en_out, .crystal_clock_en_out, .stacking_start_out,
   .lowpower_exit_out, .watchdog_run_out, .flag_clear_allow_out,
   .second_step_allow_out);
`default_nettype wire

//--- cpu_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_partner_model (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       go_stop_in,
   input  wire logic       go_wait_in,
   input  wire logic [7:0] irq_delay_in,
   input  wire logic       cpu_clk_en_in,
   input  wire logic       stacking_start_in,
   output logic            stop_instr_out,
   output logic            wait_instr_out,
   output logic            cpu_irq_out
);
   // ----------------------------------------------------------------
   // Level interrupt source, held until stacking acknowledges it
   // ----------------------------------------------------------------
   logic [7:0] cnt_q;
   logic       armed_q;
   always_ff @(posedge clk_in) begin
      stop_instr_out <= go_stop_in && !rst_in;
      wait_instr_out <= go_wait_in && !rst_in;
      if (rst_in || stacking_start_in) begin
         cpu_irq_out <= 1'b0;
         armed_q     <= 1'b0;
      end else if (go_stop_in || go_wait_in) begin
         armed_q <= (irq_delay_in != 8'h00);
         cnt_q   <= irq_delay_in;
      end else if (armed_q && !cpu_clk_en_in) begin
         // Delay zero leaves the exit to a break from the bench
         cnt_q <= cnt_q - 8'h01;
         if (cnt_q == 8'h01) begin
            cpu_irq_out <= 1'b1;
            armed_q     <= 1'b0;
         end
      end
   end
endmodule : cpu_partner_model
`default_nettype wire

//--- test_lowpower_mode_and_sys_status.sv
`timescale 1ns/1ps
`default_nettype none
module test_lowpower_mode_and_sys_status;
   localparam int          LONG = 64;
   localparam logic [15:0] BS   = lowpower_pkg::BREAK_STATUS_IDX;
   localparam logic [15:0] RC   = lowpower_pkg::RESET_CAUSE_STATUS_IDX;
   localparam logic [15:0] BF   = lowpower_pkg::BREAK_FLAG_CONTROL_IDX;
   localparam logic [15:0] CT   = lowpower_pkg::LOWPOWER_CONTROL_IDX;
   logic        clk_in, rst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
   logic [17:0] avs_address_in;
   logic [31:0] avs_writedata_in, avs_readdata_out, d;
   logic        stop_instr_in, wait_instr_in, cpu_irq_in, break_irq_in;
   logic        break_mode_in, clear_imask_out, cpu_clk_en_out;
   logic        periph_clk_en_out, base_clock_output_en_out;
   logic        crystal_clock_en_out, stacking_start_out, lowpower_exit_out;
   logic        watchdog_run_out, flag_clear_allow_out, second_step_allow_out;
   logic [5:0]  cause;
   logic        go_stop, go_wait, reset_pin;
   logic [7:0]  irq_delay;
   int          num_errors, samples_checked, cycles, n;
   lowpower_mode_and_sys_status #(.STOP_REC_LONG(LONG))
      lowpower_mode_and_sys_status_i (.clk_in, .rst_in, .avs_address_in,
      .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in(4'hF),
      .avs_readdata_out, .avs_waitrequest_out, .stop_instr_in, .wait_instr_in,
      .cpu_irq_in, .break_irq_in, .reset_pin_in(reset_pin), .break_mode_in,
      .clear_imask_out, .cpu_clk_en_out, .periph_clk_en_out,
      .base_clock_output_en_out, .crystal_clock_en_out, .stacking_start_out,
      .lowpower_exit_out, .watchdog_run_out, .por_cause_in(cause[5]),
      .pin_cause_in(cause[4]), .wdog_cause_in(cause[3]),
      .ill_opcode_cause_in(cause[2]), .ill_fetch_cause_in(cause[1]),
      .low_voltage_cause_in(cause[0]), .flag_clear_allow_out,
      .second_step_allow_out);
   cpu_partner_model cpu_partner_model_i (.clk_in, .rst_in,
      .go_stop_in(go_stop), .go_wait_in(go_wait), .irq_delay_in(irq_delay),
      .cpu_clk_en_in(cpu_clk_en_out), .stacking_start_in(stacking_start_out),
      .stop_instr_out(stop_instr_in), .wait_instr_out(wait_instr_in),
      .cpu_irq_out(cpu_irq_in));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic stop_test;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test
   task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_reg
   task automatic check_bit(input logic got, input logic exp);
      check_reg({31'h0, got}, {31'h0, exp});
   endtask : check_bit
   // Request held until waitrequest is sampled low, then one idle cycle
   task automatic xfer(input logic wr, input logic [15:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
      avs_address_in   <= {idx, 2'b00};
      avs_read_in      <= !wr;
      avs_write_in     <= wr;
      avs_writedata_in <= wd;
      do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
      rd = avs_readdata_out;
      avs_read_in  <= 1'b0;
      avs_write_in <= 1'b0;
      @(posedge clk_in);
   endtask : xfer
   task automatic wr(input logic [15:0] idx, input logic [31:0] v);
      logic [31:0] x;
      xfer(1'b1, idx, v, x);
   endtask : wr
   task automatic rd_chk(input logic [15:0] idx, input logic [31:0] e);
      logic [31:0] x;
      xfer(1'b0, idx, 32'h0, x);
      check_reg(x, e);
   endtask : rd_chk
   task automatic do_reset(input int cyc, input logic [5:0] c);
      rst_in <= 1'b1;
      cause  <= c;
      repeat (cyc) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      cause <= 6'h00;
      repeat (2) @(posedge clk_in);
   endtask : do_reset
   // Delay zero means the exit comes from a break instead of an interrupt
   task automatic lp_cycle(input logic stop, input logic [7:0] dly,
                           output int cnt);
      irq_delay <= dly;
      go_stop   <= stop;
      go_wait   <= !stop;
      @(posedge clk_in);
      go_stop <= 1'b0;
      go_wait <= 1'b0;
      while (cpu_clk_en_out !== 1'b0) @(posedge clk_in);
      check_bit(clear_imask_out, 1'b1);
      check_bit(base_clock_output_en_out, !stop);
      check_bit(periph_clk_en_out, !stop);
      check_bit(crystal_clock_en_out, !stop);
      if (dly == 8'h00) begin
         repeat (4) @(posedge clk_in);
         break_irq_in <= 1'b1;
      end
      cnt = 0;
      while (stacking_start_out !== 1'b1) begin
         @(posedge clk_in);
         if (lowpower_exit_out === 1'b1) cnt++;
      end
      break_irq_in <= 1'b0;
   endtask : lp_cycle
   function automatic logic [31:0] cause_exp(input logic [5:0] c);
      return c[5] ? 32'h80 : {24'h0, 1'b0, c[4:1], 1'b0, c[0], 1'b0};
   endfunction : cause_exp
   // ----------------------------------------------------------------
   // Clock, timeout and main sequence
   // ----------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         stop_test();
      end
   end
   initial begin
      {rst_in, avs_address_in, avs_read_in, avs_write_in, reset_pin} = '0;
      {avs_writedata_in, break_irq_in, break_mode_in, cause} = '0;
      {go_stop, go_wait, irq_delay, num_errors, samples_checked, cycles} = '0;
      d = $urandom(54546);
      do_reset(20, 6'h20);
      rd_chk(BS, 32'h0);
      rd_chk(BF, 32'h0);
      rd_chk(RC, 32'h80);
      rd_chk(RC, 32'h0);
      rd_chk(16'hFE02, 32'h0);
      for (int i = 0; i < 10; i++) begin
         logic [5:0] c;
         c = (i < 5) ? 6'h01 << i : 6'($urandom);
         do_reset(2, c);
         rd_chk(RC, cause_exp(c));
         rd_chk(RC, 32'h0);
      end
      for (int i = 0; i < 4; i++) begin
         d = $urandom;
         wr(BF, d);
         rd_chk(BF, {24'h0, d[7], 7'h0});
         break_mode_in <= 1'b1;
         repeat (2) @(posedge clk_in);
         check_bit(flag_clear_allow_out, d[7]);
         check_bit(second_step_allow_out, 1'b0);
         break_mode_in <= 1'b0;
         repeat (2) @(posedge clk_in);
         check_bit(second_step_allow_out, 1'b1);
      end
      wr(CT, 32'h2);
      @(posedge clk_in);
      check_bit(watchdog_run_out, 1'b0);
      wr(CT, 32'h0);
      @(posedge clk_in);
      check_bit(watchdog_run_out, 1'b1);
      lp_cycle(1'b0, 8'(1 + $urandom % 8), n);
      check_bit(n >= 1 && n <= 6, 1'b1);
      wr(CT, 32'h1);
      lp_cycle(1'b1, 8'(1 + $urandom % 16), n);
      check_bit(n >= 32 && n <= 40, 1'b1);
      wr(CT, 32'h0);
      lp_cycle(1'b1, 8'(1 + $urandom % 16), n);
      check_bit(n >= LONG && n <= LONG + 8, 1'b1);
      rd_chk(BS, 32'h0);
      lp_cycle(1'b1, 8'h00, n);
      check_bit(n >= LONG && n <= LONG + 8, 1'b1);
      rd_chk(BS, 32'h2);
      wr(BS, 32'hFF);
      rd_chk(BS, 32'h2);
      wr(BS, 32'h0);
      rd_chk(BS, 32'h0);
      lp_cycle(1'b0, 8'h00, n);
      rd_chk(BS, 32'h2);
      // Stop left by a pulse on the reset pin alone
      irq_delay <= 8'h00;
      go_stop   <= 1'b1;
      @(posedge clk_in);
      go_stop <= 1'b0;
      repeat (3) @(posedge clk_in);
      reset_pin <= 1'b1;
      @(posedge clk_in);
      reset_pin <= 1'b0;
      @(posedge clk_in);
      check_bit(lowpower_exit_out, 1'b1);
      while (cpu_clk_en_out !== 1'b1) @(posedge clk_in);
      check_bit(periph_clk_en_out, 1'b1);
      do_reset(2, 6'h10);
      rd_chk(BS, 32'h0);
      stop_test();
   end
endmodule : test_lowpower_mode_and_sys_status
`default_nettype wire
